// [logic/pcs_defs.vh]
// constants for the clock synthesizer control block
// assumes it is included by bare name from the logic and test files
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH

// clock rate and relock time
`define PCS_CLK_MHZ          20
`define PCS_LOCK_TIME_US     1000
// product of the two above, sized so the 16-bit count takes it as is
`define PCS_LOCK_CYCLES      16'h4E20

// register map
`define PCS_ADDR_W           8
`define PCS_SYNTH_CONTROL    8'h04

// clock modes, latched after reset
`define PCS_MODE_EXT         2'h0
`define PCS_MODE_FAST        2'h1
`define PCS_MODE_SLOW        2'h2

// upper byte field positions
`define PCS_BYPASS_BIT       15
`define PCS_SLOW_MULT_BIT    14
`define PCS_FAST_MULT_HI     14
`define PCS_FAST_MULT_LO     12
`define PCS_SLOW_SCALE_HI    13
`define PCS_SCALE_HI         10
`define PCS_SCALE_LO         8

// lower byte field positions
`define PCS_BUS_DIV_BIT      7
`define PCS_STOP_OSC_BIT     6
`define PCS_LOSS_OSC_BIT     5
`define PCS_BACKUP_BIT       4
`define PCS_LOCK_BIT         3
`define PCS_LOSS_RST_BIT     2
`define PCS_SLEEP_SRC_BIT    1
`define PCS_SLEEP_EXT_BIT    0

// reset values of the upper byte per mode, and of the lower byte
`define PCS_RST_SLOW         8'h3F
`define PCS_RST_FAST_P0      8'h80
`define PCS_RST_FAST_P1      8'h30
`define PCS_RST_EXT          8'h80
`define PCS_RST_LOW          8'h08

// writable masks of the upper byte per mode
`define PCS_MASK_SLOW        8'hFF
`define PCS_MASK_FAST        8'hF7
`define PCS_MASK_EXT         8'h87
// writable lower bits: backup and lock flags are read only
`define PCS_MASK_LOW         8'hE7

`endif

// [logic/pcs_lock_mon.v]
// lock monitor: models the loop's acquisition time after any
// comparator input change; assumes one clock and async reset
`timescale 1ns/1ps
module pcs_lock_mon #(
  parameter CYC_W                  = 16,
  parameter [CYC_W-1:0] LOCK_CYCLES = 16'h4E20
) (
  // clock and reset
  input  wire             clk_sys_i,
  input  wire             rst_n_i,
  // control
  input  wire             loop_on_i,
  input  wire             relock_i,
  // status
  output reg              locked_o
);

  reg [CYC_W-1:0] cnt;

  // acquisition counter, restarted on every comparator change;
  // relock wins over loop off, since the mode capture pulse comes
  // while the loop still reads off and must start a loop mode unlocked
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt      <= {CYC_W{1'b0}};
      locked_o <= 1'b0;
    end else if (relock_i) begin
      cnt      <= {CYC_W{1'b0}};
      locked_o <= 1'b0;                        // relock after change [R3]
    end else if (!loop_on_i) begin
      cnt      <= {CYC_W{1'b0}};
      locked_o <= 1'b1;                        // loop off reads locked [R21]
    end else if (!locked_o) begin
      if (cnt == LOCK_CYCLES - 1'b1) begin
        locked_o <= 1'b1;                      // divided vco meets ref [R2]
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule

// [logic/pcs_synth_ctrl.v]
// clock synthesizer control: mode latch, control register, lock
// flag, reset hold and clock ratio outputs
// assumes straps and ref clock are asynchronous pins
//
// What this block does
// R1: oscillator runs at 4x or 2x system clock
// R2: lock flag reports loop lock to software
// R3: any comparator input change forces relocking
// R4: hold reset at power-up until lock
// R5: slow mode ratio 4(Y+1)2^(2W+X), up to 2048
// R6: slow mode bypass doubles clock, lock kept
// R7: fast mode ratio (W+1)/((2-X)2^Y)
// R8: fast scale and bypass keep loop lock
// R9: external mode ratio 1/((2-X)2^Y)
// R10: bypass bit removes divide-by-two in every mode
// R11: mode chosen at reset from supply pin, shadow
// R12: register readable any time, writable once the mode is latched, lock in bit 3
// R13: upper byte layout follows the mode
// R14: slow mode upper byte resets to 3F
// R15: fast mode resets to 80 or 30 by preset
// R16: external mode upper byte resets to 80
// R17: every reset forces mode defaults into register
// R18: software keeps programmed clock within limits
// R19: shadow bit 0 fast, 1 slow, supply high
// R20: supply pin low selects external clock mode
// R21: lock reads 1 when loop off or locked
// R22: external mode upper byte reset uses 80
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "pcs_defs.vh"
module pcs_synth_ctrl #(
  parameter [15:0] LOCK_CYCLES = `PCS_LOCK_CYCLES
) (
  // clock and reset
  input  wire                   clk_sys_i,
  input  wire                   rst_n_i,
  // configuration pins, sampled after reset
  input  wire                   synth_supply_pin_i,
  input  wire                   ref_speed_shadow_bit_i,
  input  wire                   fast_ref_preset_shadow_bit_i,
  // reference or external clock pin
  input  wire                   ref_clock_input_i,
  // register port
  input  wire [`PCS_ADDR_W-1:0] addr_i,
  input  wire [15:0]            wr_data_i,
  input  wire                   wr_i,
  input  wire                   rd_i,
  output reg  [15:0]            rd_data_o,
  // mode and lock status
  output reg  [1:0]             clock_mode_o,
  output reg                    synth_locked_flag_o,
  output reg                    rst_hold_n_o,
  // clock ratio outputs
  output reg  [11:0]            sys_mult_o,
  output reg  [3:0]             sys_div_log2_o,
  output reg  [2:0]             vco_per_sys_o,
  output reg                    sys_tick_o,
  // lower byte controls
  output reg                    bus_clock_divide_select_o,
  output reg                    stop_osc_in_sleep_o,
  output reg                    clock_loss_osc_disable_o,
  output reg                    clock_loss_reset_enable_o,
  output reg                    sleep_core_clock_source_o,
  output reg                    sleep_external_clock_drive_o
);

  // writable mask of the upper byte for a mode
  function [7:0] upper_mask;
    input [1:0] mode;
    begin
      case (mode)
        `PCS_MODE_SLOW: upper_mask = `PCS_MASK_SLOW;
        `PCS_MODE_FAST: upper_mask = `PCS_MASK_FAST;
        default:        upper_mask = `PCS_MASK_EXT;
      endcase
    end
  endfunction

  // pin synchronisers
  reg        sup_s1, sup_s2;
  reg        spd_s1, spd_s2;
  reg        pre_s1, pre_s2;
  reg        ref_s1, ref_s2, ref_s3;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sup_s1 <= 1'b0;
      sup_s2 <= 1'b0;
      spd_s1 <= 1'b0;
      spd_s2 <= 1'b0;
      pre_s1 <= 1'b0;
      pre_s2 <= 1'b0;
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
    end else begin
      sup_s1 <= synth_supply_pin_i;
      sup_s2 <= sup_s1;
      spd_s1 <= ref_speed_shadow_bit_i;
      spd_s2 <= spd_s1;
      pre_s1 <= fast_ref_preset_shadow_bit_i;
      pre_s2 <= pre_s1;
      ref_s1 <= ref_clock_input_i;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
    end
  end

  wire ref_rise = ref_s2 & ~ref_s3;

  // strap capture waits for the synchronisers to fill
  reg  [1:0] init_cnt;
  reg        mode_valid;
  wire       capture = (init_cnt == 2'h2) & ~mode_valid;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_cnt <= 2'h0;
    end else if (init_cnt != 2'h2) begin
      init_cnt <= init_cnt + 2'h1;
    end
  end

  // mode decode from supply pin and speed shadow bit
  reg  [1:0] next_mode;
  reg  [7:0] next_upper_rst;

  always @* begin
    if (!sup_s2) begin
      next_mode      = `PCS_MODE_EXT;          // supply low wins [R20]
      next_upper_rst = `PCS_RST_EXT;           // [R16] [R22]
    end else if (spd_s2) begin
      next_mode      = `PCS_MODE_SLOW;         // [R19]
      next_upper_rst = `PCS_RST_SLOW;          // [R14]
    end else begin
      next_mode      = `PCS_MODE_FAST;         // [R19]
      next_upper_rst = pre_s2 ? `PCS_RST_FAST_P1 : `PCS_RST_FAST_P0; // [R15]
    end
  end

  // control register storage
  reg  [7:0] upper;
  reg  [7:0] lower;
  wire       locked;
  wire       hit    = (addr_i == `PCS_SYNTH_CONTROL);
  wire       do_wr  = wr_i & hit & mode_valid;
  wire [7:0] umask  = upper_mask(clock_mode_o);
  wire [7:0] next_upper = (upper & ~umask) | (wr_data_i[15:8] & umask);

  // feedback fields that feed the phase comparator
  reg        fb_change;

  always @* begin
    case (clock_mode_o)
      `PCS_MODE_SLOW: fb_change = (next_upper[6:0] != upper[6:0]);
      `PCS_MODE_FAST: fb_change = (next_upper[6:4] != upper[6:4]);
      default:        fb_change = 1'b0;
    endcase
  end

  // mode latch and register; defaults loaded after every reset
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_valid   <= 1'b0;
      clock_mode_o <= `PCS_MODE_EXT;
      upper        <= 8'h00;
      lower        <= `PCS_RST_LOW;            // [R17]
    end else if (capture) begin
      mode_valid   <= 1'b1;
      clock_mode_o <= next_mode;               // [R11]
      upper        <= next_upper_rst;          // [R17]
      lower        <= `PCS_RST_LOW;            // [R17]
    end else if (do_wr) begin
      upper <= next_upper;                     // layout by mode [R13]
      lower <= wr_data_i[7:0] & `PCS_MASK_LOW; // [R12]
    end
  end

  // loop runs only in the two reference modes
  wire loop_on = mode_valid & (clock_mode_o != `PCS_MODE_EXT);
  wire relock  = capture | (do_wr & fb_change); // [R3]

  pcs_lock_mon #(
    .CYC_W       (16),
    .LOCK_CYCLES (LOCK_CYCLES)
  ) u_lock (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .loop_on_i (loop_on),
    .relock_i  (relock),
    .locked_o  (locked)
  );

  // read image: reserved bits zero, lock flag live
  wire [7:0] rd_lower = {lower[7:5], 1'b0, locked, lower[2:0]}; // [R12] [R21]
  wire [15:0] rd_image = {upper & umask, rd_lower};

  // read data stand for one cycle; unmapped reads give zero
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 16'h0000;
    end else if (rd_i & hit) begin
      rd_data_o <= rd_image;                   // any time [R12]
    end else begin
      rd_data_o <= 16'h0000;
    end
  end

  // reset hold: released at the first lock only, later relocks
  // do not reassert it since that would reset the whole device
  reg powered;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      powered             <= 1'b0;
      rst_hold_n_o        <= 1'b0;
      synth_locked_flag_o <= 1'b0;
    end else begin
      synth_locked_flag_o <= mode_valid & locked; // [R2]
      if (mode_valid & locked & ~relock) begin
        powered      <= 1'b1;
        rst_hold_n_o <= 1'b1;                  // [R4]
      end else begin
        rst_hold_n_o <= powered;
      end
    end
  end

  // field views
  wire       byp    = upper[`PCS_BYPASS_BIT-8];
  wire       w_slow = upper[`PCS_SLOW_MULT_BIT-8];
  wire [5:0] y_slow = upper[`PCS_SLOW_SCALE_HI-8:`PCS_SCALE_LO-8];
  wire [2:0] w_fast = upper[`PCS_FAST_MULT_HI-8:`PCS_FAST_MULT_LO-8];
  wire [2:0] y3     = upper[`PCS_SCALE_HI-8:`PCS_SCALE_LO-8];

  // clock ratio: fsys = fref * mult / 2^div_log2
  reg  [11:0] next_mult;
  reg  [3:0]  next_div;
  wire [6:0]  y_plus = {1'b0, y_slow} + 7'h01;
  wire [11:0] slow_base = {3'h0, y_plus, 2'h0};
  wire [1:0]  slow_shift = {w_slow, byp};

  always @* begin
    case (clock_mode_o)
      `PCS_MODE_SLOW: begin
        // bypass acts after the oscillator, feedback unchanged [R6]
        next_mult = slow_base << slow_shift;   // [R5]
        next_div  = 4'h0;
      end
      `PCS_MODE_FAST: begin
        // scale and bypass sit in the output path only [R8]
        next_mult = {9'h000, w_fast} + 12'h001; // [R7]
        next_div  = {1'b0, y3} + {3'h0, ~byp};  // [R7] [R10]
      end
      default: begin
        next_mult = 12'h001;                   // loop bypassed [R9]
        next_div  = {1'b0, y3} + {3'h0, ~byp};  // [R9] [R10]
      end
    endcase
  end

  // registered ratio and oscillator multiple
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_mult_o     <= 12'h001;
      sys_div_log2_o <= 4'h0;
      vco_per_sys_o  <= 3'h4;
    end else begin
      sys_mult_o     <= next_mult;
      sys_div_log2_o <= next_div;
      vco_per_sys_o  <= byp ? 3'h2 : 3'h4;     // keeps 50% duty [R1]
    end
  end

  // external mode output divider on synchronised ref edges;
  // limited to ref below half of the block clock
  reg  [8:0] tick_cnt;
  wire [8:0] tick_div = (byp ? 9'h001 : 9'h002) << y3; // [R10]

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt   <= 9'h000;
      sys_tick_o <= 1'b0;
    end else if (!mode_valid || clock_mode_o != `PCS_MODE_EXT) begin
      tick_cnt   <= 9'h000;
      sys_tick_o <= 1'b0;
    end else if (ref_rise) begin
      if (tick_cnt >= tick_div - 9'h001) begin
        tick_cnt   <= 9'h000;
        sys_tick_o <= 1'b1;                    // [R9]
      end else begin
        tick_cnt   <= tick_cnt + 9'h001;
        sys_tick_o <= 1'b0;
      end
    end else begin
      sys_tick_o <= 1'b0;
    end
  end

  // lower byte controls driven out
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_clock_divide_select_o    <= 1'b0;
      stop_osc_in_sleep_o          <= 1'b0;
      clock_loss_osc_disable_o     <= 1'b0;
      clock_loss_reset_enable_o    <= 1'b0;
      sleep_core_clock_source_o    <= 1'b0;
      sleep_external_clock_drive_o <= 1'b0;
    end else begin
      bus_clock_divide_select_o    <= lower[`PCS_BUS_DIV_BIT];
      stop_osc_in_sleep_o          <= lower[`PCS_STOP_OSC_BIT];
      clock_loss_osc_disable_o     <= lower[`PCS_LOSS_OSC_BIT];
      clock_loss_reset_enable_o    <= lower[`PCS_LOSS_RST_BIT];
      sleep_core_clock_source_o    <= lower[`PCS_SLEEP_SRC_BIT];
      sleep_external_clock_drive_o <= lower[`PCS_SLEEP_EXT_BIT];
    end
  end

endmodule

// [test/pcs_synth_ctrl_properties.sv]
// checker for the clock synthesizer control block
// assumes it is bound to pcs_synth_ctrl and sees only its ports
`timescale 1ns/1ps
`include "pcs_defs.vh"
module pcs_props (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  // register port
  input wire logic [7:0]  addr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rd_data_o,
  // status and ratio outputs
  input wire logic [1:0]  clock_mode_o,
  input wire logic        synth_locked_flag_o,
  input wire logic        rst_hold_n_o,
  input wire logic [11:0] sys_mult_o,
  input wire logic [3:0]  sys_div_log2_o,
  input wire logic [2:0]  vco_per_sys_o,
  input wire logic        sys_tick_o,
  input wire logic        bus_clock_divide_select_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // a read of the control register, then its answer cycle
  sequence s_rd_hit;
    rd_i && addr_i == `PCS_SYNTH_CONTROL ##1 1'b1;
  endsequence
  sequence s_rd_miss;
    !(rd_i && addr_i == `PCS_SYNTH_CONTROL) ##1 1'b1;
  endsequence
  // the three mode ratio checks wait for hold release, as the image is blank during init
  a_idle_read_zero: assert property (s_rd_miss |-> rd_data_o == 16'h0000)
    else $error("read data not zero");
  a_vco_ratio_match: assert property (s_rd_hit |-> vco_per_sys_o == (rd_data_o[15] ? 3'd2 : 3'd4))
    else $error("vco ratio wrong");
  a_low_byte_copy: assert property (s_rd_hit |-> bus_clock_divide_select_o == rd_data_o[7] && !rd_data_o[4])
    else $error("lower byte copy wrong");
  a_fast_mode_ratio: assert property (s_rd_hit ##0 rst_hold_n_o && clock_mode_o == `PCS_MODE_FAST |->
    sys_mult_o == {9'h000, rd_data_o[14:12]} + 12'h001 &&
    sys_div_log2_o == {1'b0, rd_data_o[10:8]} + {3'h0, ~rd_data_o[15]})
    else $error("fast ratio wrong");
  a_ext_mode_ratio: assert property (s_rd_hit ##0 rst_hold_n_o && clock_mode_o == `PCS_MODE_EXT |->
    sys_mult_o == 12'h001 && sys_div_log2_o == {1'b0, rd_data_o[10:8]} + {3'h0, ~rd_data_o[15]})
    else $error("external ratio wrong");
  a_slow_mode_ratio: assert property (s_rd_hit ##0 rst_hold_n_o && clock_mode_o == `PCS_MODE_SLOW |->
    sys_mult_o == ({6'h00, rd_data_o[13:8]} + 12'h001) << ({1'b0, rd_data_o[14], rd_data_o[15]} + 3'd2)
    && sys_div_log2_o == 4'h0)
    else $error("slow ratio wrong");
  a_hold_sticky: assert property (rst_hold_n_o |=> rst_hold_n_o)
    else $error("reset hold fell");
  a_hold_after_lock: assert property ($rose(rst_hold_n_o) |-> synth_locked_flag_o)
    else $error("reset released before lock");
  a_ext_always_locked: assert property (rst_hold_n_o && clock_mode_o == `PCS_MODE_EXT |-> synth_locked_flag_o)
    else $error("external mode not locked");
  a_mode_fixed: assert property (rst_hold_n_o |=> $stable(clock_mode_o))
    else $error("mode changed after reset");
  a_tick_ext_pulse: assert property (sys_tick_o |-> clock_mode_o == `PCS_MODE_EXT ##1 !sys_tick_o)
    else $error("tick outside external mode");
endmodule

// [test/pcs_synth_ctrl_tb.sv]
// testbench for the clock synthesizer control block
// assumes pcs_synth_ctrl and pcs_props are compiled before it
`timescale 1ns/1ps
module pcs_synth_ctrl_tb;
  reg         clk_sys_i = 1'b0;
  reg         rst_n_i   = 1'b0;
  reg         sup = 1'b0, spd = 1'b0, pre = 1'b0, wr = 1'b0, rd = 1'b0;
  reg  [2:0]  ref_cnt = 3'h0;
  reg  [7:0]  addr = 8'h00;
  reg  [15:0] wdat = 16'h0000, v;
  wire [15:0] rdat;
  wire [11:0] mult;
  wire [5:0]  low;
  wire [3:0]  divl;
  wire [2:0]  vco;
  wire [1:0]  mode;
  wire        lock, hold, tick;
  integer     n_fail = 0, total_checks = 0, n_tick = 0, t0, i;
  // 50 ns clock; reference is clk/8 so edges never sit back to back
  always #25 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) ref_cnt <= ref_cnt + 3'h1;
  always @(posedge clk_sys_i) if (tick === 1'b1) n_tick <= n_tick + 1;
  pcs_synth_ctrl #(.LOCK_CYCLES(16'd16)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .synth_supply_pin_i(sup),
    .ref_speed_shadow_bit_i(spd), .fast_ref_preset_shadow_bit_i(pre),
    .ref_clock_input_i(ref_cnt[2]), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rdat), .clock_mode_o(mode), .synth_locked_flag_o(lock), .rst_hold_n_o(hold),
    .sys_mult_o(mult), .sys_div_log2_o(divl), .vco_per_sys_o(vco), .sys_tick_o(tick),
    .bus_clock_divide_select_o(low[5]), .stop_osc_in_sleep_o(low[4]),
    .clock_loss_osc_disable_o(low[3]), .clock_loss_reset_enable_o(low[2]),
    .sleep_core_clock_source_o(low[1]), .sleep_external_clock_drive_o(low[0]));
  task wrap_up; begin
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end endtask
  task chk(input [15:0] seen, input [15:0] exp, input string nm); begin
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  end endtask
  // straps change with reset held; first request four edges after release
  task boot(input s, input p, input f); begin
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0; sup <= s; spd <= p; pre <= f;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  end endtask
  task wrr(input [7:0] a, input [15:0] d); begin
    @(posedge clk_sys_i);
    addr <= a; wdat <= d; wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  end endtask
  // read data stands only in the cycle after the strobe
  task rdr(input [7:0] a, input [15:0] exp); begin
    @(posedge clk_sys_i);
    addr <= a; rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 chk(rdat, exp, "register");
  end endtask
  task ratio(input [11:0] m, input [3:0] d, input [2:0] vv); begin
    chk({4'h0, mult}, {4'h0, m}, "mult");
    chk({12'h000, divl}, {12'h000, d}, "div");
    chk({13'h0000, vco}, {13'h0000, vv}, "vco");
  end endtask
  // lock wait is bounded; extra edge lets the flag settle
  task wl; begin
    for (i = 0; i < 100 && lock !== 1'b1; i = i + 1) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
  end endtask
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    n_fail = n_fail + 1;
    wrap_up;
  end
  initial begin
    boot(1'b0, 1'b1, 1'b1);
    chk({14'h0000, mode}, 16'h0000, "mode");
    rdr(8'h04, 16'h8008);
    chk({15'h0000, hold}, 16'h0001, "hold");
    t0 = n_tick;
    repeat (64) @(posedge clk_sys_i);
    chk({15'h0000, (n_tick - t0 >= 7 && n_tick - t0 <= 9)}, 16'h0001, "ticks");
    wrr(8'h04, 16'h7BFF);
    rdr(8'h04, 16'h03EF);
    ratio(12'd1, 4'd4, 3'd4);
    chk({10'h000, low}, 16'h003F, "low");
    // divide by 16 ref edges: one tick per 128 clocks
    t0 = n_tick;
    repeat (256) @(posedge clk_sys_i);
    chk({15'h0000, (n_tick - t0 >= 1 && n_tick - t0 <= 3)}, 16'h0001, "slow ticks");
    wrr(8'h10, 16'h0000);
    rdr(8'h10, 16'h0000);
    rdr(8'h04, 16'h03EF);
    boot(1'b1, 1'b0, 1'b0);
    chk({14'h0000, mode}, 16'h0001, "mode");
    rdr(8'h04, 16'h8000);
    chk({15'h0000, hold}, 16'h0000, "hold");
    wl;
    rdr(8'h04, 16'h8008);
    ratio(12'd1, 4'd0, 3'd2);
    wrr(8'h04, 16'h7800);
    rdr(8'h04, 16'h7000);
    ratio(12'd8, 4'd1, 3'd4);
    wl;
    wrr(8'h04, 16'hF108);
    rdr(8'h04, 16'hF108);
    ratio(12'd8, 4'd1, 3'd2);
    boot(1'b1, 1'b0, 1'b1);
    wl;
    rdr(8'h04, 16'h3008);
    ratio(12'd4, 4'd1, 3'd4);
    boot(1'b1, 1'b1, 1'b0);
    chk({14'h0000, mode}, 16'h0002, "mode");
    wl;
    rdr(8'h04, 16'h3F08);
    ratio(12'd256, 4'd0, 3'd4);
    wrr(8'h04, 16'h4000);
    rdr(8'h04, 16'h4000);
    ratio(12'd16, 4'd0, 3'd4);
    wl;
    wrr(8'h04, 16'hC000);
    rdr(8'h04, 16'hC008);
    ratio(12'd32, 4'd0, 3'd2);
    wrap_up;
  end
endmodule
bind pcs_synth_ctrl pcs_props i_props (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .rd_i(rd_i),
  .rd_data_o(rd_data_o), .clock_mode_o(clock_mode_o), .synth_locked_flag_o(synth_locked_flag_o),
  .rst_hold_n_o(rst_hold_n_o), .sys_mult_o(sys_mult_o), .sys_div_log2_o(sys_div_log2_o),
  .vco_per_sys_o(vco_per_sys_o), .sys_tick_o(sys_tick_o),
  .bus_clock_divide_select_o(bus_clock_divide_select_o));
